// >>> logic/sbt_core.sv
/*
  byte-wide synchronous serial port, master or slave, with a receive fifo.
  assumes pin inputs already synchronous to i_clock; control bits are ports.
*/
module sbt_core
  import sbt_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_srst,
  input  wire logic       i_power_gate_bit,
  input  wire logic       i_port_enable_bit,
  input  wire logic       i_transfer_irq_enable,
  input  wire logic       i_lsb_first,
  input  wire logic       i_master_set,
  input  wire logic       i_clk_polarity,
  input  wire logic       i_clk_phase,
  input  wire logic       i_rate_select_high,
  input  wire logic       i_rate_select_low,
  input  wire logic       i_double_speed_bit,
  input  wire logic       i_ss_is_input,
  input  wire logic       i_data_wr,
  input  wire logic [7:0] i_data_wdata,
  input  wire logic       i_rx_rd,
  input  wire logic       i_flag_clear,
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_miso,
  input  wire logic       i_ss_n,
  output logic            o_sck,
  output logic            o_sck_oe_n,
  output logic            o_mosi,
  output logic            o_mosi_oe_n,
  output logic            o_miso,
  output logic            o_miso_oe_n,
  output logic            o_master_select_bit,
  output logic            o_transfer_done_flag,
  output logic            o_write_collision,
  output logic            o_irq,
  output logic            o_busy,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_valid
);
  // ---------------------------------------------------------------
  // enable and mode
  // ---------------------------------------------------------------
  logic          en;
  logic          master_q;
  logic          mfault;
  sbt_state_type st_q;
  logic [7:0]    sh_q;
  logic [3:0]    cnt_q;
  logic [6:0]    div_q;
  logic [6:0]    half;
  logic          sck_d1_q;
  logic          done_ev;
  logic [7:0]    rx_byte;
  logic          out_bit;
  logic          in_bit;
  logic          smp_edge;
  logic          set_edge;
  logic          s_active;
  logic [7:0]    fifo_data;
  logic          fifo_valid;

  assign en = i_port_enable_bit && !i_power_gate_bit;
  assign mfault = en && master_q && i_ss_is_input && !i_ss_n;
  assign s_active = en && !master_q && !i_ss_n;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      master_q <= 1'b0;
    end else if (mfault) begin
      master_q <= 1'b0;
    end else if (i_master_set) begin
      master_q <= 1'b1;
    end else if (!en) begin
      master_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // master rate divider
  // ---------------------------------------------------------------
  always_comb begin
    unique case ({i_rate_select_high, i_rate_select_low, i_double_speed_bit})
      3'b000: half = HALF_DIV4;
      3'b001: half = HALF_DIV2;
      3'b010: half = HALF_DIV16;
      3'b011: half = HALF_DIV8;
      3'b100: half = HALF_DIV64;
      3'b101: half = HALF_DIV32;
      3'b110: half = HALF_DIV128;
      3'b111: half = HALF_DIV64;
    endcase
  end

  // ---------------------------------------------------------------
  // serial bit selection and edges
  // ---------------------------------------------------------------
  assign out_bit = i_lsb_first ? sh_q[0] : sh_q[7];
  assign in_bit  = master_q ? i_miso : i_mosi;
  // slave edge detect on the system clock; sck already synchronous
  assign smp_edge = (i_sck != sck_d1_q) && ((i_sck ^ i_clk_polarity) ^ i_clk_phase);
  assign set_edge = (i_sck != sck_d1_q) && !((i_sck ^ i_clk_polarity) ^ i_clk_phase);
  assign rx_byte  = sh_q;

  // seeded from the pin itself, so no false edge follows reset
  always_ff @(posedge i_clock) begin
    sck_d1_q <= i_sck;
  end

  // ---------------------------------------------------------------
  // transfer engine
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      st_q    <= SBT_IDLE;
      sh_q    <= DATA_RESET;
      cnt_q   <= '0;
      div_q   <= '0;
      o_sck   <= 1'b0;
      o_mosi  <= 1'b0;
      o_miso  <= 1'b0;
      done_ev <= 1'b0;
    end else begin
      done_ev <= 1'b0;
      // pin values launched here so sck and data share one edge
      if (!en || mfault) begin
        st_q  <= SBT_IDLE;
        cnt_q <= '0;
        o_sck <= i_clk_polarity;
      end else if (master_q) begin
        unique case (st_q)
          SBT_IDLE: begin
            o_sck <= i_clk_polarity;
            if (i_data_wr) begin
              sh_q   <= i_data_wdata;
              o_mosi <= i_lsb_first ? i_data_wdata[0] : i_data_wdata[7];
              cnt_q  <= '0;
              div_q  <= half;
              st_q   <= SBT_LEAD;
            end
          end
          SBT_LEAD: begin
            if (div_q == 7'h01) begin
              div_q <= half;
              o_sck <= ~o_sck;
              st_q  <= SBT_TRAIL;
              // sample and setup on opposite edges
              if (!i_clk_phase) begin
                sh_q <= i_lsb_first ? {in_bit, sh_q[7:1]} : {sh_q[6:0], in_bit};
              end else begin
                o_mosi <= out_bit;
              end
            end else begin
              div_q <= div_q - 7'h01;
            end
          end
          SBT_TRAIL: begin
            if (div_q == 7'h01) begin
              div_q <= half;
              o_sck <= ~o_sck;
              cnt_q <= cnt_q + 4'h1;
              if (i_clk_phase) begin
                sh_q <= i_lsb_first ? {in_bit, sh_q[7:1]} : {sh_q[6:0], in_bit};
              end else begin
                o_mosi <= out_bit;
              end
              if (cnt_q == BIT_LAST - 4'h1) begin
                st_q    <= SBT_IDLE;
                done_ev <= 1'b1;
              end else begin
                st_q <= SBT_LEAD;
              end
            end else begin
              div_q <= div_q - 7'h01;
            end
          end
          default: st_q <= SBT_IDLE;
        endcase
      end else begin
        st_q <= SBT_IDLE;
        if (i_ss_n) begin
          cnt_q <= '0;
          if (i_data_wr) begin
            sh_q   <= i_data_wdata;
            o_miso <= i_lsb_first ? i_data_wdata[0] : i_data_wdata[7];
          end else begin
            o_miso <= out_bit;
          end
        end else begin
          if (i_data_wr && cnt_q == '0) begin
            sh_q   <= i_data_wdata;
            o_miso <= i_lsb_first ? i_data_wdata[0] : i_data_wdata[7];
          end else if (smp_edge) begin
            sh_q  <= i_lsb_first ? {in_bit, sh_q[7:1]} : {sh_q[6:0], in_bit};
            cnt_q <= cnt_q + 4'h1;
          end else if (set_edge) begin
            o_miso <= out_bit;
          end else if (cnt_q == BIT_LAST) begin
            cnt_q   <= '0;
            done_ev <= 1'b1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic busy;
  assign busy = master_q ? (st_q != SBT_IDLE) : (s_active && cnt_q != '0);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_transfer_done_flag <= 1'b0;
    end else if (done_ev || mfault) begin
      o_transfer_done_flag <= 1'b1;
    end else if (i_flag_clear) begin
      o_transfer_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_write_collision <= 1'b0;
    end else if (i_data_wr && busy) begin
      o_write_collision <= 1'b1;
    end else if (i_flag_clear) begin
      o_write_collision <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= i_transfer_irq_enable && (o_transfer_done_flag || done_ev);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_busy              <= 1'b0;
      o_master_select_bit <= 1'b0;
    end else begin
      o_busy              <= busy;
      o_master_select_bit <= master_q;
    end
  end

  // ---------------------------------------------------------------
  // pins: select line is never driven here
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_sck_oe_n  <= 1'b1;
      o_mosi_oe_n <= 1'b1;
      o_miso_oe_n <= 1'b1;
    end else begin
      o_sck_oe_n  <= !(en && master_q);
      o_mosi_oe_n <= !(en && master_q);
      o_miso_oe_n <= !s_active;
    end
  end

  // ---------------------------------------------------------------
  // receive buffering
  // ---------------------------------------------------------------
  sbt_fifo_if #(.WIDTH(BYTE_BITS)) rxf ();
  assign rxf.data  = rx_byte;
  assign rxf.valid = done_ev && !mfault;

  sbt_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .wr      (rxf.snk),
    .o_data  (fifo_data),
    .o_valid (fifo_valid),
    .i_ready (i_rx_rd)
  );

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_rx_data  <= DATA_RESET;
      o_rx_valid <= 1'b0;
    end else begin
      o_rx_data  <= fifo_data;
      o_rx_valid <= fifo_valid;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_gate_blocks: assert property (@(posedge i_clock) disable iff (i_srst)
    i_power_gate_bit |=> o_sck_oe_n && o_mosi_oe_n && o_miso_oe_n)
    else $error("pins driven while gated");
  a_miso_idle: assert property (@(posedge i_clock) disable iff (i_srst)
    (!master_q && i_ss_n) |=> o_miso_oe_n)
    else $error("miso driven while deselected");
  a_fault_slave: assert property (@(posedge i_clock) disable iff (i_srst)
    mfault |=> !master_q && o_transfer_done_flag)
    else $error("mode fault not handled");
  a_done_sets: assert property (@(posedge i_clock) disable iff (i_srst)
    done_ev |=> o_transfer_done_flag)
    else $error("done flag missing");
  a_irq_follow: assert property (@(posedge i_clock) disable iff (i_srst)
    (o_transfer_done_flag && i_transfer_irq_enable) |=> o_irq)
    else $error("irq missing");
  a_start_write: assert property (@(posedge i_clock) disable iff (i_srst)
    (en && master_q && !mfault && st_q == SBT_IDLE && i_data_wr) |=> st_q == SBT_LEAD)
    else $error("master did not start");
  a_collide_flag: assert property (@(posedge i_clock) disable iff (i_srst)
    (i_data_wr && busy) |=> o_write_collision)
    else $error("collision not flagged");
  a_slave_reset: assert property (@(posedge i_clock) disable iff (i_srst)
    (en && !master_q && !mfault && !i_master_set && i_ss_n) |=> cnt_q == '0)
    else $error("slave count not cleared");
  a_master_dirs: assert property (@(posedge i_clock) disable iff (i_srst)
    (en && master_q) |=> !o_sck_oe_n && !o_mosi_oe_n && o_miso_oe_n)
    else $error("master pin directions");
  c_master_done: cover property (@(posedge i_clock) master_q && done_ev);
  c_slave_done: cover property (@(posedge i_clock) !master_q && done_ev);
  c_fault: cover property (@(posedge i_clock) mfault);
  c_collide: cover property (@(posedge i_clock) i_data_wr && busy);
endmodule // sbt_core

// >>> logic/sbt_pkg.sv
/*
  shared constants for the byte-wide serial port core.
  assumes a single 25 MHz system clock and synchronous reset.
*/
package sbt_pkg;
  localparam int unsigned CLK_MHZ       = 25;
  localparam int unsigned BYTE_BITS     = 8;
  localparam int unsigned FIFO_DEPTH    = 32;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  // half-period counts for master divider, system clocks per sck half
  localparam logic [6:0]  HALF_DIV2     = 7'h01;
  localparam logic [6:0]  HALF_DIV4     = 7'h02;
  localparam logic [6:0]  HALF_DIV8     = 7'h04;
  localparam logic [6:0]  HALF_DIV16    = 7'h08;
  localparam logic [6:0]  HALF_DIV32    = 7'h10;
  localparam logic [6:0]  HALF_DIV64    = 7'h20;
  localparam logic [6:0]  HALF_DIV128   = 7'h40;
  localparam logic [3:0]  BIT_LAST      = 4'h8;

  typedef enum logic [2:0] {
    SBT_IDLE  = 3'b001,
    SBT_LEAD  = 3'b010,
    SBT_TRAIL = 3'b100
  } sbt_state_type;
endpackage

// >>> logic/sbt_fifo_if.sv
/*
  valid/ready carrier between the core and its receive fifo.
  assumes both ends on i_clock.
*/
interface sbt_fifo_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// >>> logic/sbt_fifo.sv
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock, synchronous active-high reset.
*/
module sbt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  sbt_fifo_if.snk               wr,
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic             full;
  logic             empty;

  assign full    = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty   = (wp_q == rp_q);
  assign wr.ready = !full;
  assign o_valid = !empty;
  assign o_data  = mem[rp_q[AW-1:0]];

  always_ff @(posedge i_clock) begin
    if (wr.valid && !full) begin
      mem[wp_q[AW-1:0]] <= wr.data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      wp_q <= '0;
    end else if (wr.valid && !full) begin
      wp_q <= wp_q + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rp_q <= '0;
    end else if (i_ready && !empty) begin
      rp_q <= rp_q + 1'b1;
    end
  end
endmodule // sbt_fifo

// >>> tb/sbt_peer.sv
/*
  far-side serial peer: slave to a master core, master to a slave core via xfer.
  assumes its own drives change one unit after a system clock edge.
*/
module sbt_peer (
  input  wire logic i_clock,
  input  wire logic i_cpol,
  input  wire logic i_cpha,
  input  wire logic i_slave,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_miso,
  input  wire logic i_ss_n,
  output logic      o_miso,
  output logic      o_sck,
  output logic      o_mosi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic [7:0] sr_q;
  // ------
  // slave role, all four modes
  // ------
  initial begin
    {o_miso, o_sck, o_mosi, tx_q, rx_q, sr_q} = '0;
  end
  always @(negedge i_ss_n) begin
    sr_q = tx_q;
    if (!i_cpha) o_miso = tx_q[7];
  end
  // released line shows inverse of last bit
  always @(posedge i_ss_n) o_miso = ~o_miso;
  always @(i_sck) begin
    if (!i_ss_n && i_slave && ((i_sck != i_cpol) ^ i_cpha)) begin
      rx_q = {rx_q[6:0], i_mosi};
    end else if (!i_ss_n && i_slave) begin
      o_miso = i_cpha ? sr_q[7] : sr_q[6];
      sr_q = sr_q << 1;
    end
  end
  // ------
  // master role, mode 0, msb first
  // ------
  task automatic xfer(input logic [7:0] tx, input int nbits);
    for (int i = 7; i > 7 - nbits; i--) begin
      @(posedge i_clock);
      #1 o_mosi = tx[i];
      repeat (4) @(posedge i_clock);
      #1 o_sck = 1'b1;
      rx_q = {rx_q[6:0], i_miso};
      repeat (4) @(posedge i_clock);
      #1 o_sck = 1'b0;
    end
    @(posedge i_clock);
    #1 o_mosi = ~o_mosi;
  endtask
endmodule // sbt_peer

// >>> tb/sbt_core_tb.sv
/*
  self-checking bench for sbt_core with a serial peer on its pins.
  assumes the logic/ package, fifo, interface and tb/sbt_peer.sv.
*/
module sbt_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, srst, gate, en, irq_en, lsb, mset, cpol, cpha, ssin, wr, rd, fclr, ss_n;
  logic [2:0] rate;
  logic [7:0] wd, rxd;
  logic       sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic       mbit, done, wcol, irq, busy, rxv, p_miso, p_sck, p_mosi;
  wire        sck_w  = sck_oe_n ? p_sck : sck_o;
  wire        mosi_w = mosi_oe_n ? p_mosi : mosi_o;
  wire        miso_w = miso_oe_n ? p_miso : miso_o;
  int         num_errors, checks_done, cycles;

  sbt_core dut_u (
    .i_clock(clk), .i_srst(srst), .i_power_gate_bit(gate), .i_port_enable_bit(en),
    .i_transfer_irq_enable(irq_en), .i_lsb_first(lsb), .i_master_set(mset),
    .i_clk_polarity(cpol), .i_clk_phase(cpha), .i_rate_select_high(rate[1]),
    .i_rate_select_low(rate[0]), .i_double_speed_bit(rate[2]), .i_ss_is_input(ssin),
    .i_data_wr(wr), .i_data_wdata(wd), .i_rx_rd(rd), .i_flag_clear(fclr), .i_sck(sck_w),
    .i_mosi(mosi_w), .i_miso(miso_w), .i_ss_n(ss_n), .o_sck(sck_o), .o_sck_oe_n(sck_oe_n),
    .o_mosi(mosi_o), .o_mosi_oe_n(mosi_oe_n), .o_miso(miso_o), .o_miso_oe_n(miso_oe_n),
    .o_master_select_bit(mbit), .o_transfer_done_flag(done), .o_write_collision(wcol),
    .o_irq(irq), .o_busy(busy), .o_rx_data(rxd), .o_rx_valid(rxv));
  sbt_peer peer_u (.i_clock(clk), .i_cpol(cpol), .i_cpha(cpha), .i_slave(mbit),
    .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w), .i_ss_n(ss_n), .o_miso(p_miso),
    .o_sck(p_sck), .o_mosi(p_mosi));

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim;
    end
  end
  // ------
  // shared tasks
  // ------
  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction
  task automatic wait_done;
    for (int n = 0; n < 3000 && done !== 1'b1; n++) tick(1);
    chk("done", 1, done);
  endtask
  task automatic read_rx(input logic [7:0] e);
    chk("rx_valid", 1, rxv);
    chk("rx_data", e, rxd);
    pulse(rd);
    tick(2);
  endtask
  task automatic mshot(input logic [7:0] w, input logic [7:0] p);
    peer_u.tx_q = p;
    ss_n = 1'b0;
    tick(1);
    wd = w;
    pulse(wr);
    wait_done;
    tick(1);
    chk("irq", irq_en, irq);
    ss_n = 1'b1;
    pulse(fclr);
    tick(2);
  endtask
  task automatic mxfer(input logic [7:0] w, p, pe, de);
    mshot(w, p);
    chk("peer_rx", pe, peer_u.rx_q);
    read_rx(de);
  endtask
  task automatic measure(input logic [6:0] h);
    int n;
    for (n = 0; n < 300 && sck_o === cpol; n++) tick(1);
    for (n = 0; n < 300 && sck_o !== cpol; n++) tick(1);
    chk("sck_half", {1'b0, h}, n[7:0]);
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_master;
    logic [7:0] w;
    logic [7:0] p;
    en = 1'b1;
    pulse(mset);
    tick(1);
    chk("oe_n", 8'h01, {5'h0, sck_oe_n, mosi_oe_n, miso_oe_n});
    for (int m = 0; m < 5; m++) begin
      {cpol, cpha} = m[1:0];
      lsb = (m == 4);
      irq_en = m[0];
      w = 8'hA5 + m[7:0];
      p = 8'h3C ^ m[7:0];
      tick(2);
      mxfer(w, p, lsb ? rev(w) : w, lsb ? rev(p) : p);
    end
  endtask
  task automatic t_rates;
    // half periods of /4 /16 /64 /128, then double speed /2 /8 /32 /64
    logic [6:0] h [8] = '{7'h02, 7'h08, 7'h20, 7'h40, 7'h01, 7'h04, 7'h10, 7'h20};
    {cpol, cpha, lsb, irq_en} = '0;
    for (int r = 0; r < 8; r++) begin
      rate = r[2:0];
      tick(1);
      fork
        mxfer(r[7:0], 8'hC0, r[7:0], 8'hC0);
        measure(h[r]);
      join
    end
  endtask
  task automatic t_collide;
    rate = '0;
    peer_u.tx_q = 8'h11;
    ss_n = 1'b0;
    wd = 8'h96;
    pulse(wr);
    tick(3);
    chk("busy", 1, busy);
    wd = 8'h69;
    pulse(wr);
    tick(1);
    chk("wcol", 1, wcol);
    wait_done;
    ss_n = 1'b1;
    chk("peer_rx", 8'h96, peer_u.rx_q);
    pulse(fclr);
    tick(1);
    chk("wcol", 0, wcol);
    read_rx(8'h11);
  endtask
  task automatic t_gate;
    gate = 1'b1;
    tick(2);
    pulse(wr);
    tick(40);
    chk("done", 0, done);
    chk("busy", 0, busy);
    gate = 1'b0;
    pulse(mset);
    tick(2);
  endtask
  task automatic t_fifo;
    rate = 3'h4;
    for (int i = 0; i < 33; i++) mshot(i[7:0], i[7:0]);
    for (int i = 0; i < 32; i++) read_rx(i[7:0]);
    chk("rx_valid", 0, rxv);
  endtask
  task automatic t_fault;
    ssin = 1'b1;
    tick(2);
    ss_n = 1'b0;
    tick(4);
    chk("master", 0, mbit);
    chk("done", 1, done);
    chk("sck_oe_n", 1, sck_oe_n);
    {ss_n, mset, ssin, rate} = 6'h20;
    pulse(fclr);
    tick(2);
  endtask
  task automatic t_slave;
    irq_en = 1'b1;
    chk("oe_n", 8'h07, {5'h0, sck_oe_n, mosi_oe_n, miso_oe_n});
    wd = 8'h5A;
    pulse(wr);
    peer_u.xfer(8'hFF, 8);
    tick(4);
    chk("done", 0, done);
    ss_n = 1'b0;
    tick(2);
    chk("miso_oe_n", 0, miso_oe_n);
    peer_u.xfer(8'hF0, 4);
    ss_n = 1'b1;
    tick(2);
    chk("done", 0, done);
    pulse(wr);
    ss_n = 1'b0;
    peer_u.xfer(8'hC3, 8);
    wait_done;
    tick(1);
    chk("irq", 1, irq);
    chk("peer_rx", 8'h5A, peer_u.rx_q);
    ss_n = 1'b1;
    wd = 8'h77;
    pulse(wr);
    pulse(fclr);
    ss_n = 1'b0;
    peer_u.xfer(8'h96, 8);
    wait_done;
    chk("peer_rx", 8'h77, peer_u.rx_q);
    ss_n = 1'b1;
    tick(3);
    read_rx(8'hC3);
    read_rx(8'h96);
    chk("rx_valid", 0, rxv);
  endtask

  initial begin
    {clk, gate, en, irq_en, lsb, mset, cpol, cpha, ssin, wr, rd, fclr} = '0;
    {srst, ss_n, rate, wd} = 13'h1800;
    {num_errors, checks_done, cycles} = '0;
    tick(20);
    srst = 1'b0;
    tick(1);
    chk("oe_n", 8'h07, {5'h0, sck_oe_n, mosi_oe_n, miso_oe_n});
    chk("flags", 8'h00, {2'h0, mbit, done, wcol, irq, busy, rxv});
    t_master;
    t_rates;
    t_collide;
    t_gate;
    t_fifo;
    t_fault;
    t_slave;
    end_sim;
  end
endmodule // sbt_core_tb
